/* src/imd_fifo.sv */
/*
  Small first-word-fall-through FIFO with a registered read word.
  Assumes one clock, an active-low asynchronous reset and a power-of-two
  depth; pointers wrap by overflow.
*/
`timescale 1ns/1ns
module imd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [WIDTH-1:0] data_r;
  wire push;
  wire pop;
  wire [AW-1:0] rdPtr_nxt;
  wire [AW:0] count_nxt;
  wire [WIDTH-1:0] data_nxt;

  // handshake and next-state selection
  assign inReady = (count_r != FULL_COUNT);
  assign outValid = (count_r != '0);
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign rdPtr_nxt = pop ? rdPtr_r + AW'(1) : rdPtr_r;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  // bypass the word being written when it becomes the head
  assign data_nxt = (push && wrPtr_r == rdPtr_nxt) ? inData : mem[rdPtr_nxt];
  assign outData = data_r;

  // storage array, data only, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers, level and the registered head word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      data_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + AW'(1);
      end
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      data_r <= data_nxt;
    end
  end
endmodule

/* src/imd_mailbox.sv */
/*
  Mailbox between the comm processor and the host processor: package of
  constants, then the mailbox itself with its outbound FIFO.
  Assumes both processors share sys_clk and present their I/O
  instructions as one-cycle strobes synchronous to it.
*/
// How it works
// - outbound write in flag mode sets host interrupt flag
// - flag gated by enable, always readable
// - host read of outbound clears flag
// - host write loads inbound, sets ready flag
// - comm read of inbound clears ready flag
// - sender never sees flags being cleared
// - DMA-in write raises channel-in request
// - channel-in request also raises DMA busy
// - acknowledge drops channel-in and busy
// - DMA-out write raises channel-out, data ignored
// - channel-out request also raises DMA busy
// - acknowledge captures host data, drops request
// - comm mode write loads mode control register
package imd_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int MODE_W = 8;
  // mode control register field positions
  localparam int DIRECT_INT_BIT = 0;
  localparam int DMA_FROM_HOST_BIT = 1;
  localparam int DMA_TO_HOST_BIT = 2;
  // reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // dma request state, gray along idle -> request -> idle
  typedef enum logic [1:0] {
    IMD_IDLE = 2'h0,
    IMD_CHAN_IN = 2'h1,
    IMD_CHAN_OUT = 2'h2
  } imd_state_t;
endpackage

`timescale 1ns/1ns
module imd_mailbox (
  input wire logic sys_clk,
  input wire logic arst_n,
  // comm processor side
  input wire logic commOutWrite,
  input wire logic commModeWrite,
  input wire logic [imd_pkg::DATA_W-1:0] commWriteData,
  output logic commOutReady,
  input wire logic commInRead,
  output logic [imd_pkg::DATA_W-1:0] commReadData,
  output logic commTestFlagOne,
  output logic commTestFlagTwo,
  // host processor side
  input wire logic hostInRead,
  output logic [imd_pkg::DATA_W-1:0] hostReadData,
  input wire logic hostOutWrite,
  input wire logic [imd_pkg::DATA_W-1:0] hostWriteData,
  input wire logic hostIntEnable,
  output logic hostInterrupt,
  output logic hostTestFlagFour,
  output logic channelInRequest,
  output logic channelOutRequest,
  input wire logic channelAcknowledge,
  input wire logic [imd_pkg::DATA_W-1:0] hostDmaData,
  output logic dmaBusyFlag
);
  logic [imd_pkg::MODE_W-1:0] mode_r;
  logic [imd_pkg::DATA_W-1:0] inbound_r;
  logic [imd_pkg::DATA_W-1:0] inbound_nxt;
  logic intFlag_r;
  logic intFlag_nxt;
  logic extReady_r;
  logic extReady_nxt;
  imd_pkg::imd_state_t state_r;
  imd_pkg::imd_state_t state_nxt;

  wire directIntMode;
  wire dmaToHostMode;
  wire dmaFromHostMode;
  wire queueWrite;
  wire fifoReady;
  wire fifoValid;
  wire fifoPop;
  wire ioPop;
  wire dmaInPop;
  wire pushTaken;
  wire chanOutStart;
  wire chanInStart;
  wire inAck;
  wire outAck;

  // mode decode; direct interrupt wins over both dma bits
  assign directIntMode = mode_r[imd_pkg::DIRECT_INT_BIT];
  assign dmaToHostMode = ~directIntMode & mode_r[imd_pkg::DMA_TO_HOST_BIT];
  assign dmaFromHostMode = ~directIntMode & ~dmaToHostMode
    & mode_r[imd_pkg::DMA_FROM_HOST_BIT];

  // outbound words enter the FIFO in flag mode and dma-in mode only
  assign queueWrite = commOutWrite & (directIntMode | dmaToHostMode);
  assign pushTaken = queueWrite & fifoReady;
  assign commOutReady = fifoReady;

  // host read pops the word in flag mode
  assign ioPop = hostInRead & directIntMode & fifoValid;
  // acknowledge of channel-in hands the word over
  assign inAck = (state_r == imd_pkg::IMD_CHAN_IN) & channelAcknowledge;
  assign dmaInPop = inAck;
  assign fifoPop = ioPop | dmaInPop;
  assign outAck = (state_r == imd_pkg::IMD_CHAN_OUT) & channelAcknowledge;

  // a queued word in dma-in mode starts a channel-in cycle
  assign chanInStart = dmaToHostMode & fifoValid;
  // an outbound write in dma-out mode starts channel-out only from idle; one during a pending request is dropped
  assign chanOutStart = commOutWrite & dmaFromHostMode;

  // outbound buffer between comm writes and host reads
  imd_fifo #(
    .WIDTH(imd_pkg::DATA_W),
    .DEPTH(imd_pkg::FIFO_DEPTH)
  ) uOutFifo (
    .clk(sys_clk),
    .arst_n(arst_n),
    .inValid(queueWrite),
    .inReady(fifoReady),
    .inData(commWriteData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(hostReadData)
  );

  // write sets the flag; set wins over a same-cycle clear
  // host read clears the flag otherwise
  assign intFlag_nxt = (pushTaken & directIntMode)
    | (intFlag_r & ~ioPop);

  // host write sets ready; comm read clears it
  assign extReady_nxt = hostOutWrite | (extReady_r & ~commInRead);

  // host write loads inbound; ack captures dma data
  assign inbound_nxt = outAck ? hostDmaData
    : (hostOutWrite ? hostWriteData : inbound_r);

  // dma request sequencing, one request at a time
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      imd_pkg::IMD_IDLE: begin
        if (chanInStart) begin
          state_nxt = imd_pkg::IMD_CHAN_IN;
        end else if (chanOutStart) begin
          state_nxt = imd_pkg::IMD_CHAN_OUT;
        end
      end
      imd_pkg::IMD_CHAN_IN: begin
        if (channelAcknowledge) begin
          state_nxt = imd_pkg::IMD_IDLE;
        end
      end
      imd_pkg::IMD_CHAN_OUT: begin
        if (channelAcknowledge) begin
          state_nxt = imd_pkg::IMD_IDLE;
        end
      end
      default: begin
        state_nxt = imd_pkg::IMD_IDLE;
      end
    endcase
  end

  // reset clears flags, requests and the mode register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= imd_pkg::MODE_RESET;
      inbound_r <= imd_pkg::DATA_RESET;
      intFlag_r <= imd_pkg::FLAG_RESET;
      extReady_r <= imd_pkg::FLAG_RESET;
      state_r <= imd_pkg::IMD_IDLE;
    end else begin
      if (commModeWrite) begin
        mode_r <= commWriteData;
      end
      inbound_r <= inbound_nxt;
      intFlag_r <= intFlag_nxt;
      extReady_r <= extReady_nxt;
      state_r <= state_nxt;
    end
  end

  // interrupt only when enabled, test flag always visible
  assign hostInterrupt = intFlag_r & hostIntEnable;
  assign hostTestFlagFour = intFlag_r;
  // no clear indication reaches the sending side
  assign commTestFlagOne = extReady_r;
  assign commReadData = inbound_r;
  assign channelInRequest = (state_r == imd_pkg::IMD_CHAN_IN);
  assign channelOutRequest = (state_r == imd_pkg::IMD_CHAN_OUT);
  assign dmaBusyFlag = channelInRequest | channelOutRequest;
  assign commTestFlagTwo = dmaBusyFlag;

  // checks on the mailbox behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  int_set_a:
    assert property (queueWrite && fifoReady && directIntMode
      |=> hostTestFlagFour)
    else $error("outbound write did not set host flag");

  int_clear_a:
    assert property (ioPop && !queueWrite |=> !hostTestFlagFour)
    else $error("host read did not clear host flag");

  host_irq_a:
    assert property (!hostIntEnable |-> !hostInterrupt)
    else $error("interrupt raised while disabled");

  irq_follow_a:
    assert property (hostTestFlagFour && hostIntEnable |-> hostInterrupt)
    else $error("enabled flag gave no interrupt");

  ready_set_a:
    assert property (hostOutWrite |=> commTestFlagOne
      && commReadData == $past(hostWriteData))
    else $error("host write did not load inbound word");

  ready_clear_a:
    assert property (commInRead && !hostOutWrite |=> !commTestFlagOne)
    else $error("comm read did not clear ready flag");

  chan_in_a:
    assert property (queueWrite && fifoReady && dmaToHostMode
      && !fifoValid && state_r == imd_pkg::IMD_IDLE
      |=> ##1 channelInRequest)
    else $error("dma-in write raised no channel-in");

  in_ack_a:
    assert property (channelInRequest && channelAcknowledge
      |=> !channelInRequest && !dmaBusyFlag [*1])
    else $error("acknowledge did not drop channel-in");

  chan_out_a:
    assert property (commOutWrite && dmaFromHostMode
      && state_r == imd_pkg::IMD_IDLE && !chanInStart
      |=> channelOutRequest && commTestFlagTwo)
    else $error("dma-out write raised no channel-out");

  out_capture_a:
    assert property (channelOutRequest && channelAcknowledge
      |=> commReadData == $past(hostDmaData) && !channelOutRequest)
    else $error("channel-out ack did not capture data");

  busy_track_a:
    assert property ($rose(dmaBusyFlag)
      |-> $past(chanInStart || chanOutStart))
    else $error("busy rose without a request start");

  mode_load_a:
    assert property (commModeWrite |=> mode_r == $past(commWriteData))
    else $error("mode write not stored");

  mode_hold_a:
    assert property (!commModeWrite |=> $stable(mode_r))
    else $error("mode changed with no mode write");

  // flags stand until their reader acts, the inbound word until it is loaded
  int_stand_a:
    assert property (hostTestFlagFour && !ioPop |=> hostTestFlagFour)
    else $error("host flag dropped without a host read");

  ready_stand_a:
    assert property (commTestFlagOne && !commInRead |=> commTestFlagOne)
    else $error("ready flag dropped without a comm read");

  inbound_hold_a:
    assert property (!hostOutWrite && !outAck |=> $stable(commReadData))
    else $error("inbound word changed with no load");

  // requests stand until acknowledged, busy with them
  in_stand_a:
    assert property (channelInRequest && !channelAcknowledge
      |=> channelInRequest && dmaBusyFlag)
    else $error("channel-in dropped before acknowledge");

  out_stand_a:
    assert property (channelOutRequest && !channelAcknowledge
      |=> channelOutRequest && commTestFlagTwo)
    else $error("channel-out dropped before acknowledge");

  out_quiet_a:
    assert property (commOutWrite && dmaFromHostMode && !hostTestFlagFour
      |=> !hostTestFlagFour)
    else $error("dma-out write raised the host flag");

  in_restart_a:
    assert property (dmaToHostMode && fifoValid
      && state_r == imd_pkg::IMD_IDLE |=> channelInRequest)
    else $error("queued word raised no channel-in");

  // independent count of queued outbound words, for the FIFO flags
  localparam int QW = $clog2(imd_pkg::FIFO_DEPTH) + 1;
  localparam logic [QW-1:0] QUEUE_FULL = QW'(imd_pkg::FIFO_DEPTH);
  logic [QW-1:0] queued_r;
  logic [QW-1:0] queued_nxt;
  assign queued_nxt = queued_r + QW'(pushTaken) - QW'(fifoPop & fifoValid);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      queued_r <= '0;
    end else begin
      queued_r <= queued_nxt;
    end
  end

  fifo_full_a:
    assert property (commOutReady == (queued_r != QUEUE_FULL))
    else $error("outbound ready disagrees with word count");

  fifo_empty_a:
    assert property (fifoValid == (queued_r != '0))
    else $error("outbound valid disagrees with word count");

  // main scenarios reached
  flag_reply_c:
    cover property (hostOutWrite ##[1:20] commInRead);
  io_round_c:
    cover property (pushTaken && directIntMode ##[1:20] ioPop);
  dma_in_c:
    cover property (channelInRequest ##[1:20] channelAcknowledge);
  dma_out_c:
    cover property (channelOutRequest && channelAcknowledge
      ##1 commInRead);
  fifo_full_c:
    cover property (queueWrite && !fifoReady);
endmodule

/* dv/imd_host_model.sv */
/*
  host processor dma model: acknowledges each channel request after
  ACK_DELAY+1 cycles and steps its buffer pointer.
  assumes requests stand until acknowledged, one at a time.
*/
`timescale 1ns/1ns
module imd_host_model #(
  parameter int ACK_DELAY = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic channel_in_request,
  input wire logic channel_out_request,
  input wire logic [7:0] dma_to_host_bit,
  output logic ack,
  output logic [7:0] dma_from_host_bit,
  output logic [7:0] lastIn
);
  logic [7:0] pointer;
  logic [3:0] cnt;
  logic [7:0] word;
  // buffer word at pointer; released bus shows its inverse
  assign word = 8'ha0 + pointer;
  assign dma_from_host_bit = ack ? word : ~word;
  // delay, one-cycle ack, capture inbound word
  // pointer stepped as ack drops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      pointer <= 8'h00;
      lastIn <= 8'h00;
    end else if (ack) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      pointer <= pointer + 8'h01;
      if (channel_in_request) lastIn <= dma_to_host_bit;
    end else if (channel_in_request || channel_out_request) begin
      if (cnt == 4'(ACK_DELAY)) ack <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end
endmodule

/* dv/interprocessor_mailbox_dma_bench.sv */
/*
  bench for the mailbox: strobe tasks for both processors, host dma
  model on the channel side.
  assumes one-cycle strobes taken on the rising edge of sys_clk.
*/
`timescale 1ns/1ns
module interprocessor_mailbox_dma_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] stb = 5'h00;
  logic [7:0] cData = 8'h00;
  logic [7:0] hData = 8'h00;
  logic intEn = 1'b0;
  logic cReady, tf1, tf2, hInt, tf4, cIn, cOut, ack, busy;
  logic [7:0] cRead, hRead, dmaData, lastIn;
  logic [3:0] watch;
  int errors = 0;
  int n_compared = 0;
  int i;
  assign watch = {tf4, cOut, cIn, busy};
  imd_mailbox u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .commOutWrite(stb[0]), .commModeWrite(stb[1]),
    .commWriteData(cData), .commOutReady(cReady),
    .commInRead(stb[2]), .commReadData(cRead),
    .commTestFlagOne(tf1), .commTestFlagTwo(tf2),
    .hostInRead(stb[3]), .hostReadData(hRead),
    .hostOutWrite(stb[4]), .hostWriteData(hData),
    .hostIntEnable(intEn), .hostInterrupt(hInt),
    .hostTestFlagFour(tf4), .channelInRequest(cIn),
    .channelOutRequest(cOut), .channelAcknowledge(ack),
    .hostDmaData(dmaData), .dmaBusyFlag(busy)
  );
  imd_host_model #(.ACK_DELAY(3)) u_host (
    .sys_clk(sys_clk), .arst_n(arst_n), .channel_in_request(cIn),
    .channel_out_request(cOut), .dma_to_host_bit(hRead), .ack(ack),
    .dma_from_host_bit(dmaData), .lastIn(lastIn)
  );
  // 100 ns clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one-cycle strobe: 0 out, 1 mode, 2 comm rd, 3 host rd, 4 host wr
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge sys_clk);
    stb <= 5'h01 << which;
    cData <= d;
    hData <= d;
    @(posedge sys_clk);
    stb <= 5'h00;
    #1;
  endtask
  task automatic waitBit(input int idx, input logic lvl);
    for (i = 0; i < 40 && watch[idx] !== lvl; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 40) begin
      errors++;
      finish_test();
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    check({tf1, tf2, tf4, cIn, cOut, busy, hInt, cReady}, 8'h01);
    check(cRead, 8'h00);
    strobe(0, 8'h99);
    check(tf4, 1'b0);
    $display("reset test done");
    strobe(1, 8'h01);
    strobe(0, 8'h5a);
    check({tf4, hInt}, 2'h2);
    check(hRead, 8'h5a);
    @(posedge sys_clk);
    intEn <= 1'b1;
    #1;
    check(hInt, 1'b1);
    strobe(3, 8'h00);
    check({tf4, hInt, tf1}, 3'h0);
    strobe(4, 8'hc3);
    check(tf1, 1'b1);
    check(cRead, 8'hc3);
    check(tf4, 1'b0);
    strobe(2, 8'h00);
    check(tf1, 1'b0);
    $display("flag mode test done");
    for (int k = 0; k < 8; k++) strobe(0, 8'h10 + 8'(k));
    check(cReady, 1'b0);
    strobe(0, 8'hee);
    for (int k = 0; k < 8; k++) begin
      repeat (2) @(posedge sys_clk);
      #1;
      check(hRead, 8'h10 + 8'(k));
      strobe(3, 8'h00);
    end
    check({cReady, tf4}, 2'h2);
    $display("fifo test done");
    strobe(1, 8'h04);
    strobe(0, 8'h77);
    waitBit(1, 1'b1);
    check({busy, tf2, cOut}, 3'h6);
    waitBit(1, 1'b0);
    check({busy, tf2, tf4}, 3'h0);
    check(lastIn, 8'h77);
    $display("dma in test done");
    strobe(1, 8'h02);
    strobe(0, 8'h33);
    waitBit(2, 1'b1);
    check({busy, tf2, cIn}, 3'h6);
    waitBit(2, 1'b0);
    check(busy, 1'b0);
    check(cRead, 8'ha1);
    check(tf1, 1'b0);
    strobe(2, 8'h00);
    check(tf1, 1'b0);
    strobe(0, 8'h44);
    waitBit(2, 1'b1);
    waitBit(2, 1'b0);
    check(cRead, 8'ha2);
    $display("dma out test done");
    finish_test();
  end
endmodule
